// ==== hw/asp_pkg.sv ====
/*
  Constants, register layouts and carriers for the async serial port.
  Assumes a single 250 MHz clock and byte-addressed Avalon-MM access.
*/
// Summary of operation
// [RULE1] CLK pin source must stay below 1.6 MHz when selected.
// [RULE2] Software loads the divisor only while rx_allow and tx_side_init_n are zero.
// [RULE3] prescale_choice picks oscillator/2 or oscillator/32 as divider source.
// [RULE4] Baud is f/32(N+1), f/512(N+1) or f(CLK)/16(N+1).
// [RULE5] outside_clock_pick selects the CLK pin as divider source.
// [RULE6] With handshake_pin_func zero the handshake pin is a 1-bit port.
// [RULE7] handshake_pin_dir zero means input, one means output.
// [RULE8] parity_on adds a parity bit on transmit and checks it on receive.
// [RULE9] parity_polarity picks even or odd parity for both directions.
// [RULE10] Frame config selects character and stop length for both directions; the receiver ignores halt_bits_count and checks one stop bit.
// [RULE11] tx_allow permits transmit, rx_allow permits receive.
// [RULE12] tx_irq_allow and rx_irq_allow enable the two interrupt requests.
// [RULE13] handshake_pin_func one makes the pin a clear-to-send input.
// [RULE14] In port mode handshake_pin_out sets the driven pin level.
// [RULE15] tx_side_init_n zero holds the whole transmit side initialised.
// [RULE16] Writing error_clear one clears all error flags; it reads zero.
// [RULE17] tx_buf_free_flag is one while the transmit buffer is empty; the code reads it zero while tx_side_init_n is zero.
// [RULE18] rx_buf_full_flag is set on a received character, cleared by reading it.
// [RULE19] tx_idle_flag is one when shifter and buffer are both empty; the code reads it zero while tx_side_init_n is zero.
// [RULE20] parity_fault_flag is set on received parity mismatch.
// [RULE21] overrun_flag is set when an unread character is overwritten.
// [RULE22] framing_fault_flag is set when the stop bit is sampled low.
// [RULE23] Handshake level status bit reads the pin level.
// [RULE24] Receiver samples at 16x baud, majority of three mid-bit samples.
// [RULE25] Transmit enabled when tx_allow and (port mode or handshake input low).
// [RULE26] After a stop bit send the next buffered character, else idle high.
// [RULE27] Divider source selection bits sit at frame config bits 4 and 5.
// [RULE28] Character length is seven or eight bits, stop length one or two.
// [RULE29] Reset clears all three serial registers.
package asp_pkg;

  // =========================================================
  // register map (byte addresses)
  localparam int          ADDR_W    = 5;
  localparam logic [4:0]  OFS_FRAME = 5'h00;
  localparam logic [4:0]  OFS_CTRL  = 5'h04;
  localparam logic [4:0]  OFS_FLAGS = 5'h08;
  localparam logic [4:0]  OFS_DIV   = 5'h0c;
  localparam logic [4:0]  OFS_DATA  = 5'h10;
  localparam logic [7:0]  REG_RST   = 8'h00;

  // =========================================================
  // timing
  localparam int          EXT_CLK_MAX_KHZ = 1600;
  localparam int          PRE_FAST        = 2;
  localparam int          PRE_SLOW        = 32;
  localparam logic [3:0]  PH_SAMPLE_A     = 4'h7;
  localparam logic [3:0]  PH_SAMPLE_C     = 4'h9;
  localparam logic [3:0]  PH_LAST         = 4'hf;
  localparam logic [3:0]  PH_START_SEEN   = 4'h1;
  localparam logic [3:0]  CHAR_LONG       = 4'h8;
  localparam logic [3:0]  CHAR_SHORT      = 4'h7;
  localparam int          FRAME_W         = 12;

  // =========================================================
  // register layouts
  typedef struct packed {
    logic handshake_pin_dir;
    logic spare;
    logic prescale_choice;
    logic outside_clock_pick;
    logic parity_polarity;
    logic parity_on;
    logic halt_bits_count;
    logic char_width_sel;
  } asp_frame_s;

  typedef struct packed {
    logic error_clear;
    logic tx_side_init_n;
    logic handshake_pin_out;
    logic handshake_pin_func;
    logic rx_irq_allow;
    logic rx_allow;
    logic tx_irq_allow;
    logic tx_allow;
  } asp_ctrl_s;

  typedef struct packed {
    logic hs_level;
    logic spare;
    logic framing_fault_flag;
    logic overrun_flag;
    logic parity_fault_flag;
    logic tx_idle_flag;
    logic rx_buf_full_flag;
    logic tx_buf_free_flag;
  } asp_flags_s;

  typedef enum logic [2:0] {
    ASP_RX_IDLE  = 3'b000,
    ASP_RX_START = 3'b001,
    ASP_RX_DATA  = 3'b010,
    ASP_RX_PAR   = 3'b011,
    ASP_RX_STOP  = 3'b100
  } asp_rx_e;

endpackage

// ==== hw/asp_baud_gen.sv ====
/*
  Baud source selection and programmable divider; emits a 16x tick.
  Assumes i_ext_clk is already synchronous to i_clk.
*/
`timescale 1ns/1ps
module asp_baud_gen import asp_pkg::*; #(
  parameter int DIV_W = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ext_clk,
  input  wire logic             i_outside,
  input  wire logic             i_prescale,
  input  wire logic [DIV_W-1:0] i_divisor,
  output logic                  o_tick
);

  if (DIV_W < 1) begin : g_chk
    $error("DIV_W must be at least 1");
  end

  typedef struct packed {
    logic [4:0]       pre;
    logic             ext_prev;
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } asp_bg_s;

  asp_bg_s s;
  asp_bg_s next_s;
  logic    src;

  always_comb begin
    next_s          = s;
    next_s.pre      = s.pre + 5'h01;
    next_s.ext_prev = i_ext_clk;
    next_s.tick     = 1'b0;
    if (i_outside) begin                                    // RULE5
      src = i_ext_clk & ~s.ext_prev;
    end else if (i_prescale) begin                          // RULE3
      src = s.pre == 5'(PRE_SLOW - 1);
    end else begin
      src = (s.pre & 5'(PRE_FAST - 1)) == 5'(PRE_FAST - 1);
    end
    // divide by N+1 gives the 16x oversample rate
    if (src) begin                                          // RULE4
      if (s.cnt == '0) begin
        next_s.cnt  = i_divisor;
        next_s.tick = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
    if (i_rst) begin
      next_s = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    s <= next_s;
  end

  assign o_tick = s.tick;

endmodule // asp_baud_gen

// ==== hw/asp_serial_port.sv ====
/*
  Full-duplex async serial channel with Avalon-MM register access.
  Assumes rxd, handshake and CLK pin inputs are synchronous to i_clk.
*/
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module asp_serial_port import asp_pkg::*; (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  input  wire logic              i_rxd,
  output logic                   o_txd,
  input  wire logic              i_ext_clk,
  input  wire logic              i_hs_in,
  output logic                   o_hs_out,
  output logic                   o_hs_oe,
  output logic                   o_tx_irq,
  output logic                   o_rx_irq
);

  // =========================================================
  // state
  typedef struct packed {
    asp_frame_s          frame;
    asp_ctrl_s           ctrl;
    logic [7:0]          divisor;
    logic                waitreq;
    logic [31:0]         rdata;
    logic                txd;
    logic                hs_out;
    logic                hs_oe;
    logic                tx_irq;
    logic                rx_irq;
    logic [7:0]          tx_buf;
    logic                tx_full;
    logic                tx_busy;
    logic [FRAME_W-1:0]  tx_sh;
    logic [3:0]          tx_left;
    logic [3:0]          tx_ph;
    asp_rx_e             rx_st;
    logic                rx_prev;
    logic [3:0]          rx_ph;
    logic [2:0]          rx_vote;
    logic [7:0]          rx_sh;
    logic [3:0]          rx_cnt;
    logic                rx_par;
    logic [7:0]          rx_buf;
    logic                rx_full;
    logic                pe;
    logic                ovr;
    logic                fe;
  } asp_state_s;

  asp_state_s         s;
  asp_state_s         next_s;
  logic               tick;
  logic               req;
  logic               done;
  logic               wr;
  logic               tx_en;
  logic [3:0]         nbits;
  logic               bitv;
  logic [7:0]         dmask;
  logic [7:0]         rdat;
  logic [FRAME_W-1:0] fr;
  asp_flags_s         flags;
  asp_ctrl_s          wctrl;
  logic [7:0]         rv;

  function automatic logic maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // =========================================================
  // baud source
  asp_baud_gen #(
    .DIV_W (8)
  ) u_baud (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_ext_clk  (i_ext_clk),
    .i_outside  (s.frame.outside_clock_pick),               // RULE27
    .i_prescale (s.frame.prescale_choice),
    .i_divisor  (s.divisor),
    .o_tick     (tick)
  );

  // =========================================================
  // next state
  always_comb begin
    next_s = s;
    nbits  = s.frame.char_width_sel ? CHAR_LONG : CHAR_SHORT; // RULE28 RULE10
    dmask  = s.frame.char_width_sel ? 8'hff : 8'h7f;
    rdat   = s.frame.char_width_sel ? s.rx_sh : {1'b0, s.rx_sh[7:1]};
    bitv   = maj3(s.rx_vote);                               // RULE24
    fr     = '1;
    wctrl  = asp_ctrl_s'(i_avs_writedata[7:0]);

    // transmit permitted only with handshake clear or port mode
    tx_en = s.ctrl.tx_allow &                               // RULE25 RULE11
            (~s.ctrl.handshake_pin_func | ~i_hs_in);        // RULE13

    flags                    = '0;
    flags.tx_buf_free_flag   = s.ctrl.tx_side_init_n & ~s.tx_full; // RULE17
    flags.rx_buf_full_flag   = s.rx_full;
    flags.tx_idle_flag       = flags.tx_buf_free_flag & ~s.tx_busy; // RULE19
    flags.parity_fault_flag  = s.pe;
    flags.overrun_flag       = s.ovr;
    flags.framing_fault_flag = s.fe;
    flags.hs_level           = i_hs_in;                     // RULE23 RULE6

    // bus: request taken with waitrequest high, answered next cycle
    req  = i_avs_read | i_avs_write;
    done = req & ~s.waitreq;
    wr   = i_avs_write & done & i_avs_byteenable[0];
    next_s.waitreq = ~(req & s.waitreq);
    unique case (i_avs_address)
      OFS_FRAME: rv = s.frame;
      OFS_CTRL:  rv = {1'b0, s.ctrl[6:0]};                  // RULE16
      OFS_FLAGS: rv = flags;
      OFS_DIV:   rv = s.divisor;
      OFS_DATA:  rv = s.rx_buf;
      default:   rv = REG_RST;
    endcase
    if (req & s.waitreq) begin
      next_s.rdata = {24'h000000, rv};
    end
    if (wr) begin
      unique case (i_avs_address)
        OFS_FRAME: next_s.frame = asp_frame_s'(i_avs_writedata[7:0]);
        OFS_CTRL: begin
          next_s.ctrl             = wctrl;
          next_s.ctrl.error_clear = 1'b0;
        end
        OFS_DIV:   next_s.divisor = i_avs_writedata[7:0];  // RULE2
        default: ;
      endcase
    end
    // clears first, so a same-cycle hardware set below wins
    if (wr && i_avs_address == OFS_CTRL && wctrl.error_clear) begin
      next_s.pe  = 1'b0;                                    // RULE16
      next_s.ovr = 1'b0;
      next_s.fe  = 1'b0;
    end
    if (i_avs_read && done && i_avs_address == OFS_DATA) begin
      next_s.rx_full = 1'b0;                                // RULE18
    end

    // =======================================================
    // transmitter
    fr[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < nbits) begin
        fr[1 + i] = s.tx_buf[i];
      end
    end
    if (s.frame.parity_on) begin                            // RULE8
      fr[4'h1 + nbits] = ^(s.tx_buf & dmask) ^ ~s.frame.parity_polarity; // RULE9
    end
    if (!s.ctrl.tx_side_init_n) begin                       // RULE15
      next_s.tx_full = 1'b0;
      next_s.tx_busy = 1'b0;
      next_s.tx_ph   = '0;
      next_s.txd     = 1'b1;
    end else begin
      if (tick) begin
        if (s.tx_busy) begin
          next_s.tx_ph = s.tx_ph + 4'h1;
          if (s.tx_ph == PH_LAST) begin
            if (s.tx_left == 4'h1) begin
              next_s.tx_busy = 1'b0;                        // RULE26
              next_s.txd     = 1'b1;
            end else begin
              next_s.tx_sh   = {1'b1, s.tx_sh[FRAME_W-1:1]};
              next_s.txd     = s.tx_sh[1];
              next_s.tx_left = s.tx_left - 4'h1;
            end
          end
        end else if (s.tx_full && tx_en) begin              // RULE26
          next_s.tx_sh   = fr;
          next_s.txd     = 1'b0;
          next_s.tx_busy = 1'b1;
          next_s.tx_full = 1'b0;
          next_s.tx_ph   = '0;
          next_s.tx_left = 4'h1 + nbits + 4'(s.frame.parity_on)
                           + (s.frame.halt_bits_count ? 4'h2 : 4'h1);
        end
      end
      if (wr && i_avs_address == OFS_DATA) begin
        next_s.tx_buf  = i_avs_writedata[7:0];
        next_s.tx_full = 1'b1;
      end
    end

    // =======================================================
    // receiver
    if (!s.ctrl.rx_allow) begin                             // RULE11
      next_s.rx_st   = ASP_RX_IDLE;
      next_s.rx_full = 1'b0;
      next_s.rx_prev = 1'b1;
    end else if (tick) begin
      if (s.rx_st == ASP_RX_IDLE) begin
        next_s.rx_prev = i_rxd;
        // two low samples in a row arm the start check
        if (!i_rxd && !s.rx_prev) begin                     // RULE24
          next_s.rx_st = ASP_RX_START;
          next_s.rx_ph = PH_START_SEEN;
        end
      end else begin
        next_s.rx_ph = s.rx_ph + 4'h1;
        if (s.rx_ph >= PH_SAMPLE_A && s.rx_ph <= PH_SAMPLE_C) begin
          next_s.rx_vote = {s.rx_vote[1:0], i_rxd};
        end
        if (s.rx_ph == PH_LAST) begin
          unique case (s.rx_st)
            ASP_RX_START: begin
              next_s.rx_st  = bitv ? ASP_RX_IDLE : ASP_RX_DATA;
              next_s.rx_cnt = '0;
              next_s.rx_prev = 1'b1;
            end
            ASP_RX_DATA: begin
              next_s.rx_sh  = {bitv, s.rx_sh[7:1]};
              next_s.rx_cnt = s.rx_cnt + 4'h1;
              if (s.rx_cnt + 4'h1 == nbits) begin
                next_s.rx_st = s.frame.parity_on ? ASP_RX_PAR : ASP_RX_STOP;
              end
            end
            ASP_RX_PAR: begin
              next_s.rx_par = bitv;
              next_s.rx_st  = ASP_RX_STOP;
            end
            ASP_RX_STOP: begin
              next_s.rx_buf  = rdat;
              next_s.rx_full = 1'b1;                        // RULE18
              next_s.rx_st   = ASP_RX_IDLE;
              next_s.rx_prev = bitv;
              if (s.rx_full) begin
                next_s.ovr = 1'b1;                          // RULE21
              end
              if (s.frame.parity_on &&
                  (^rdat ^ s.rx_par ^ ~s.frame.parity_polarity)) begin
                next_s.pe = 1'b1;                           // RULE20 RULE9
              end
              if (!bitv) begin
                next_s.fe = 1'b1;                           // RULE22
              end
            end
            default: next_s.rx_st = ASP_RX_IDLE;
          endcase
        end
      end
    end

    // =======================================================
    // handshake pin and interrupt requests
    next_s.hs_out = s.ctrl.handshake_pin_out;               // RULE14
    next_s.hs_oe  = ~s.ctrl.handshake_pin_func &            // RULE6 RULE13
                    s.frame.handshake_pin_dir;              // RULE7
    next_s.tx_irq = s.ctrl.tx_irq_allow & flags.tx_buf_free_flag & tx_en; // RULE12
    next_s.rx_irq = s.ctrl.rx_irq_allow & s.rx_full;        // RULE12

    if (i_rst) begin
      next_s          = '0;                                 // RULE29
      next_s.waitreq  = 1'b1;
      next_s.txd      = 1'b1;
      next_s.rx_prev  = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    s <= next_s;
  end

  // =========================================================
  // outputs, all registered
  assign o_avs_readdata    = s.rdata;
  assign o_avs_waitrequest = s.waitreq;
  assign o_txd             = s.txd;
  assign o_hs_out          = s.hs_out;
  assign o_hs_oe           = s.hs_oe;
  assign o_tx_irq          = s.tx_irq;
  assign o_rx_irq          = s.rx_irq;

endmodule // asp_serial_port

// ==== tb/asp_far_end.sv ====
/*
  Far-end serial transceiver: decodes TxD frames into a queue, sends RxD frames.
  Assumes a fixed bit time in i_clk cycles and the frame format on its inputs.
*/
`timescale 1ns/1ps
module asp_far_end #(
  parameter int BIT = 32
) (
  input  wire logic       i_clk,
  input  wire logic       i_txd,
  input  wire logic [3:0] i_nbits,
  input  wire logic       i_par_on,
  output logic            o_rxd
);
  logic [9:0] got[$];
  logic [9:0] fr;

  initial o_rxd = 1'h1;

  // ==========================================================
  // receiver: one sample in the middle of each bit, stop in bit 9
  always begin
    @(negedge i_txd);
    repeat (BIT / 2) @(posedge i_clk);
    fr = '0;
    for (int i = 0; i < i_nbits + i_par_on; i++) begin
      repeat (BIT) @(posedge i_clk);
      fr[i] = i_txd;
    end
    repeat (BIT) @(posedge i_clk);
    fr[9] = i_txd;
    got.push_back(fr);
  end

  // ==========================================================
  // sender: bits after the start bit, LSB first, stops included
  task automatic send(input logic [9:0] bits, input int n);
    @(posedge i_clk);
    o_rxd <= 1'h0;
    repeat (BIT) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_rxd <= bits[i];
      repeat (BIT) @(posedge i_clk);
    end
    o_rxd <= 1'h1;
  endtask
endmodule // asp_far_end

// ==== tb/asp_serial_port_props.sv ====
/*
  Port-level checker for asp_serial_port.
  Assumes one clock domain and BIT_CYC i_clk cycles per serial bit.
*/
`timescale 1ns/1ps
module asp_serial_port_props import asp_pkg::*; #(
  parameter int BIT_CYC = 32
) (
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic              i_avs_read,
  input wire logic              i_avs_write,
  input wire logic [31:0]       o_avs_readdata,
  input wire logic              o_avs_waitrequest,
  input wire logic              o_txd,
  input wire logic              o_hs_oe,
  input wire logic              o_tx_irq,
  input wire logic              o_rx_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ==========================================================
  // length of the current low run on txd
  logic [15:0] low_cnt;
  always_ff @(posedge i_clk) begin
    if (i_rst || o_txd) low_cnt <= 16'h0;
    else if (low_cnt != 16'hffff) low_cnt <= low_cnt + 16'h1;
  end

  // ==========================================================
  // properties
  property p_wait_one;
    $fell(o_avs_waitrequest) |=> o_avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_answer;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered next cycle");
  property p_idle_wait;
    !(i_avs_read || i_avs_write) && !$past(i_avs_read || i_avs_write) |-> o_avs_waitrequest;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("waitrequest low without request");
  property p_upper_zero;
    !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("readdata upper bits set");
  property p_ctrl_msb;
    !o_avs_waitrequest && $past(i_avs_read) && $past(i_avs_address) == OFS_CTRL
      |-> !o_avs_readdata[7];
  endproperty
  a_ctrl_msb: assert property (p_ctrl_msb) else $error("error_clear read as one");
  property p_unmapped;
    !o_avs_waitrequest && $past(i_avs_read) && $past(i_avs_address) > OFS_DATA
      |-> o_avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset_out;
    disable iff (1'h0) i_rst |=> o_txd && !o_hs_oe && !o_tx_irq && !o_rx_irq;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not in reset state");
  property p_start_len;
    $rose(o_txd) |-> low_cnt >= BIT_CYC;
  endproperty
  a_start_len: assert property (p_start_len) else $error("txd low shorter than a bit");
endmodule // asp_serial_port_props

bind asp_serial_port asp_serial_port_props #(.BIT_CYC(32)) props_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_txd(o_txd), .o_hs_oe(o_hs_oe),
  .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq)
);

// ==== tb/testbench.sv ====
/*
  Self-checking bench for asp_serial_port: registers, both serial directions,
  receive faults, handshake port and transmit gating.
  Assumes asp_far_end on the serial pins and divisor 0, prescale 0.
*/
`timescale 1ns/1ps
module testbench import asp_pkg::*;;
  localparam int BIT = 32;
  logic              clk = 1'h0;
  logic              rst = 1'h1;
  logic [ADDR_W-1:0] addr = '0;
  logic              rd = 1'h0;
  logic              wr = 1'h0;
  logic [31:0]       wdata = 32'h0;
  logic [3:0]        be = 4'h1;
  logic [31:0]       rdata;
  logic              waitreq, rxd, txd, hs_out, hs_oe, tx_irq, rx_irq;
  logic              hs_ext = 1'h0;
  logic [3:0]        nbits = 4'h8;
  logic              par_on = 1'h1;
  logic              ext_clk = 1'h0;
  logic [6:0]        ext_cnt = 7'h0;
  wire logic         hs_in = hs_oe ? hs_out : hs_ext;
  int                n_mismatch = 0;
  int                comparisons = 0;

  asp_serial_port dut_u (
    .i_clk(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_rxd(rxd), .o_txd(txd), .i_ext_clk(ext_clk),
    .i_hs_in(hs_in), .o_hs_out(hs_out), .o_hs_oe(hs_oe), .o_tx_irq(tx_irq),
    .o_rx_irq(rx_irq)
  );
  asp_far_end #(.BIT(BIT)) far_u (
    .i_clk(clk), .i_txd(txd), .i_nbits(nbits), .i_par_on(par_on), .o_rxd(rxd)
  );

  always #2 clk = ~clk;
  // CLK pin source: 160-cycle period, 640 ns, under the pin's ceiling
  always @(posedge clk) begin
    ext_cnt <= (ext_cnt == 7'h4f) ? 7'h0 : ext_cnt + 7'h1;
    ext_clk <= (ext_cnt == 7'h4f) ? ~ext_clk : ext_clk;
  end

  // ==========================================================
  // shared tasks
  task automatic report_and_stop;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    rd <= ~w;
    wr <= w;
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'h0 && n < 20);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
    if (n >= 20) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'h0, a, 8'h0, q);
    check(nm, q, {24'h0, e});
  endtask
  task automatic wait_flags(input logic [7:0] m);
    logic [31:0] q;
    for (int i = 0; i < 400; i++) begin
      bus(1'h0, OFS_FLAGS, 8'h0, q);
      if ((q[7:0] & m) === m) return;
    end
    n_mismatch++;
    report_and_stop();
  endtask
  task automatic take(input logic [9:0] e);
    logic [9:0] f;
    f = ~e;  // an empty queue must not pass
    if (far_u.got.size() > 0) f = far_u.got.pop_front();
    check("txd_frame", {22'h0, f}, {22'h0, e});
  endtask

  // ==========================================================
  // scenarios
  task automatic sc_reset;
    rchk("frame", OFS_FRAME, 8'h00);
    rchk("ctrl", OFS_CTRL, 8'h00);
    rchk("flags", OFS_FLAGS, 8'h00);
    rchk("div", OFS_DIV, 8'h00);
    rchk("rxbuf", OFS_DATA, 8'h00);
    wreg(5'h14, 8'hff);
    rchk("unmapped", 5'h14, 8'h00);
    be <= 4'h0;
    wreg(OFS_DIV, 8'hff);
    be <= 4'h1;
    rchk("div_be", OFS_DIV, 8'h00);
  endtask
  task automatic sc_tx;
    wreg(OFS_DIV, 8'h00);
    wreg(OFS_FRAME, 8'h0d);
    wreg(OFS_CTRL, 8'h43);
    rchk("flags_empty", OFS_FLAGS, 8'h05);
    wreg(OFS_DATA, 8'ha5);
    wreg(OFS_DATA, 8'h3c);
    rchk("flags_busy", OFS_FLAGS, 8'h00);
    check("tx_irq_busy", {31'h0, tx_irq}, 32'h0);
    wait_flags(8'h04);
    check("tx_irq_idle", {31'h0, tx_irq}, 32'h1);
    take({1'h1, ^8'ha5, 8'ha5});
    take({1'h1, ^8'h3c, 8'h3c});
    nbits <= 4'h7;
    wreg(OFS_FRAME, 8'h06);
    wreg(OFS_DATA, 8'hdb);
    wait_flags(8'h04);
    take({2'h2, ~^7'h5b, 7'h5b});
    nbits <= 4'h8;
    par_on <= 1'h0;
    wreg(OFS_FRAME, 8'h01);
    wreg(OFS_DATA, 8'h96);
    wait_flags(8'h04);
    take({2'h2, 8'h96});
  endtask
  task automatic sc_rx;
    nbits <= 4'h8;
    par_on <= 1'h1;
    wreg(OFS_FRAME, 8'h0d);
    wreg(OFS_CTRL, 8'h4d);
    far_u.send({1'h1, ^8'h3c, 8'h3c}, 10);
    wait_flags(8'h02);
    check("rx_irq", {31'h0, rx_irq}, 32'h1);
    rchk("rxbuf", OFS_DATA, 8'h3c);
    rchk("flags_read", OFS_FLAGS, 8'h05);
    far_u.send({1'h0, ~^8'h81, 8'h81}, 10);
    wait_flags(8'h02);
    far_u.send({1'h1, ^8'h42, 8'h42}, 10);
    wait_flags(8'h10);
    rchk("flags_err", OFS_FLAGS, 8'h3f);
    rchk("rxbuf_ovr", OFS_DATA, 8'h42);
    wreg(OFS_CTRL, 8'hcd);
    rchk("ctrl_clr", OFS_CTRL, 8'h4d);
    rchk("flags_clr", OFS_FLAGS, 8'h05);
  endtask
  task automatic sc_hs;
    wreg(OFS_FRAME, 8'h80);
    wreg(OFS_CTRL, 8'h20);
    rchk("hs_high", OFS_FLAGS, 8'h80);
    check("hs_oe", {31'h0, hs_oe}, 32'h1);
    wreg(OFS_CTRL, 8'h00);
    rchk("hs_low", OFS_FLAGS, 8'h00);
    check("hs_out", {31'h0, hs_out}, 32'h0);
    wreg(OFS_FRAME, 8'h00);
    hs_ext <= 1'h1;
    rchk("hs_in", OFS_FLAGS, 8'h80);
    check("hs_oe_in", {31'h0, hs_oe}, 32'h0);
  endtask
  task automatic sc_cts;
    wreg(OFS_FRAME, 8'h0d);
    wreg(OFS_CTRL, 8'h51);
    wreg(OFS_DATA, 8'h66);
    repeat (4 * BIT) @(posedge clk);
    check("cts_txd", {31'h0, txd}, 32'h1);
    check("cts_none", 32'(far_u.got.size()), 32'h0);
    hs_ext <= 1'h0;
    wait_flags(8'h04);
    take({1'h1, ^8'h66, 8'h66});
  endtask
  task automatic sc_init;
    wreg(OFS_CTRL, 8'h01);
    wreg(OFS_DATA, 8'h99);
    rchk("init_flags", OFS_FLAGS, 8'h00);
    repeat (4 * BIT) @(posedge clk);
    check("init_none", 32'(far_u.got.size()), 32'h0);
  endtask
  // times one start bit per baud setting; the frame is cut to keep the run short
  task automatic bit_time(input string nm, input logic [7:0] dv, input logic [7:0] fm,
                          input logic [31:0] e);
    int n;
    int t0;
    n = 0;
    wreg(OFS_CTRL, 8'h00);
    wreg(OFS_DIV, dv);
    wreg(OFS_FRAME, fm);
    wreg(OFS_CTRL, 8'h41);
    wreg(OFS_DATA, 8'hff);
    while (txd !== 1'h0 && n < 8000) begin
      @(posedge clk);
      n++;
    end
    t0 = n;
    while (txd === 1'h0 && n < 8000) begin
      @(posedge clk);
      n++;
    end
    wreg(OFS_CTRL, 8'h00);
    if (n >= 8000) begin
      n_mismatch++;
      report_and_stop();
    end
    check(nm, n - t0, e);
  endtask
  task automatic sc_clk;
    bit_time("bit_div1", 8'h01, 8'h01, 32'h40);
    bit_time("bit_slow", 8'h00, 8'h21, 32'h200);
    bit_time("bit_ext", 8'h00, 8'h11, 32'ha00);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    sc_reset();
    sc_tx();
    sc_rx();
    sc_hs();
    sc_cts();
    sc_init();
    sc_clk();
    report_and_stop();
  end
endmodule // testbench
